// ==== design/acp_cfg_reg.sv ====
// Module: one masked 8-bit configuration register
`timescale 1ns/10ps
`default_nettype none
module acp_cfg_reg
  import acp_pkg::*;
#(
  parameter logic [7:0] IDX = 8'h00,
  parameter logic [7:0] MASK = 8'hFF
) (
  input wire logic clk,       // System clock
  input wire logic rst,       // Sync reset, high
  acp_wr_if.slave wr,         // Write strobe bundle
  output logic [7:0] q        // Stored value
);

  // ==========================================================
  // Storage
  // ==========================================================
  // Masking at write time keeps reserved bits zero on readback
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= ACP_RST_VAL;
    end else if (wr.wen && (wr.idx == IDX)) begin
      q <= wr.wdata & MASK;
    end
  end

endmodule // acp_cfg_reg
`default_nettype wire

// ==== design/acp_config_top.sv ====
// Module: APB register block for the panel and memory synthesizers
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Panel count high holds bits 11:8
// - Panel count low holds bits 7:0
// - Spread gain code n gives 2**n
// - Detector gain code n gives 2**n
// - Output scaler code n divides by 2**n
// - Reference select: crystal or sample clock/16
// - Panel spread enable switches modulation
// - Panel output enable drives clock pin
// - Panel frequency uses N+8 over M+2
// - Memory reference divider is eight bits
// - Memory feedback divider is eight bits
// - Memory frequency uses N+8 over M+2
// - Memory count low holds bits 7:0
// - Memory count high holds bits 11:8
// - All fields clear to zero at reset
module acp_config_top
  import acp_pkg::*;
(
  input wire logic SYS_CLK,              // 200 MHz clock
  input wire logic RST,                  // Sync reset, high
  input wire logic PSEL,                 // APB select
  input wire logic PENABLE,              // APB access phase
  input wire logic PWRITE,               // APB direction
  input wire logic [7:0] PADDR,          // APB byte address
  input wire logic [31:0] PWDATA,        // APB write data
  input wire logic [3:0] PSTRB,          // APB byte strobes
  output logic PREADY,                   // APB ready
  output logic [31:0] PRDATA,            // APB read data
  output logic PSLVERR,                  // APB error
  output logic PANEL_CLK_OE,             // Panel clock pin enable
  output logic PANEL_SPREAD_EN,          // Panel modulation on
  output logic PANEL_REF_SEL,            // 1: sample clock / 16
  output logic [3:0] PANEL_SPREAD_GAIN,  // 1, 2, 4 or 8
  output logic [7:0] PANEL_DETECTOR_GAIN, // 1 to 128
  output logic [3:0] PANEL_SCALER_DIV,   // 1, 2, 4 or 8
  output wire logic [11:0] PANEL_SPREAD_COUNT, // Panel count
  output wire logic [8:0] PANEL_FB_TERM, // Panel N + 8
  output wire logic [8:0] PANEL_REF_TERM, // Panel M + 2
  output wire logic [11:0] MEM_SPREAD_COUNT, // Memory count
  output wire logic [8:0] MEM_FB_TERM,   // Memory N + 8
  output wire logic [8:0] MEM_REF_TERM   // Memory M + 2
);

  // ==========================================================
  // Declarations
  // ==========================================================
  acp_wr_if wr ();
  logic [7:0] q [ACP_NREG];
  logic [7:0] idx;
  logic setup;
  logic rd_hit;
  logic [7:0] rd_val;
  logic [7:0] status;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic oe_r;
  logic ss_en_r;
  logic ref_sel_r;
  logic [3:0] ss_gain_r;
  logic [7:0] det_gain_r;
  logic [3:0] osd_div_r;

  assign idx = {2'b00, PADDR[7:2]};
  assign setup = PSEL && !PENABLE;

  // ==========================================================
  // Register storage
  // ==========================================================
  // One masked register per mapped slot
  for (genvar g = 0; g < ACP_NREG; g++) begin : g_reg
    acp_cfg_reg #(
      .IDX(ACP_IDX[g]),
      .MASK(ACP_MASK[g])
    ) u_reg (
      .clk(SYS_CLK),
      .rst(RST),
      .wr(wr.slave),
      .q(q[g])
    );
  end

  // ==========================================================
  // APB slave
  // ==========================================================
  // Writes land at the completing edge; errored ones are dropped
  assign wr.wen = PSEL && PENABLE && pready_r && PWRITE
                  && PSTRB[0] && !pslverr_r;
  assign wr.idx = idx;
  assign wr.wdata = PWDATA[7:0];

  // Status shows live panel state only
  assign status = {4'h0, oe_r && ss_en_r, ref_sel_r,
                   ss_en_r && (PANEL_SPREAD_COUNT != 12'h000),
                   oe_r};

  // Address decode for reads and the error answer
  always_comb begin
    rd_hit = 1'b0;
    rd_val = 8'h00;
    for (int i = 0; i < ACP_NREG; i++) begin
      if (idx == ACP_IDX[i]) begin
        rd_hit = 1'b1;
        rd_val = q[i];
      end
    end
    if (idx == ACP_IDX_STATUS) begin
      rd_hit = 1'b1;
      rd_val = status;
    end
  end

  // Ready one cycle after setup: fixed single wait-free access
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  // Answer captured at setup; no write can slip in before it
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_val};
      pslverr_r <= !rd_hit || (PADDR[1:0] != 2'b00);
    end else if (pready_r) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  assign PREADY = pready_r;
  assign PRDATA = prdata_r;
  assign PSLVERR = pslverr_r;

  // ==========================================================
  // Panel controls and gain decode
  // ==========================================================
  // Reserved bits are masked, so a careless write cannot leak
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      oe_r <= 1'b0;
      ss_en_r <= 1'b0;
      ref_sel_r <= 1'b0;
    end else begin
      oe_r <= q[S_PO][F_OE];
      ss_en_r <= q[S_PO][F_SS_EN];
      ref_sel_r <= q[S_PO][F_REF_SEL];
    end
  end

  // Power-of-two decodes; reset gives unit gain and divide by one
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ss_gain_r <= 4'h1;
      det_gain_r <= 8'h01;
      osd_div_r <= 4'h1;
    end else begin
      ss_gain_r <= 4'h1 << q[S_PG][F_SSG_HI:F_SSG_LO];
      det_gain_r <= 8'h01 << q[S_PG][F_DET_HI:F_DET_LO];
      osd_div_r <= 4'h1 << q[S_PG][F_OSD_HI:F_OSD_LO];
    end
  end

  assign PANEL_CLK_OE = oe_r;
  assign PANEL_SPREAD_EN = ss_en_r;
  assign PANEL_REF_SEL = ref_sel_r;
  assign PANEL_SPREAD_GAIN = ss_gain_r;
  assign PANEL_DETECTOR_GAIN = det_gain_r;
  assign PANEL_SCALER_DIV = osd_div_r;

  // ==========================================================
  // Synthesizer terms
  // ==========================================================
  acp_pll_decode u_pnl (
    .clk(SYS_CLK),
    .rst(RST),
    .ref_div(q[S_PM]),
    .fb_div(q[S_PN]),
    .cnt_lo(q[S_PS0]),
    .cnt_hi(q[S_PS1]),
    .fb_term(PANEL_FB_TERM),
    .ref_term(PANEL_REF_TERM),
    .spread_cnt(PANEL_SPREAD_COUNT)
  );

  acp_pll_decode u_mem (
    .clk(SYS_CLK),
    .rst(RST),
    .ref_div(q[S_MM]),
    .fb_div(q[S_MN]),
    .cnt_lo(q[S_MS0]),
    .cnt_hi(q[S_MS1]),
    .fb_term(MEM_FB_TERM),
    .ref_term(MEM_REF_TERM),
    .spread_cnt(MEM_SPREAD_COUNT)
  );

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  // Helper views of stored fields
  logic [7:0] pg_w;
  logic [7:0] po_w;
  logic [7:0] ps1_w;
  logic [11:0] pcnt_w;
  logic [11:0] mcnt_w;
  assign pg_w = q[S_PG];
  assign po_w = q[S_PO];
  assign ps1_w = q[S_PS1];
  assign pcnt_w = {q[S_PS1][3:0], q[S_PS0]};
  assign mcnt_w = {q[S_MS1][3:0], q[S_MS0]};

  sequence s_setup_wr(logic [7:0] a);
    setup && PWRITE && (PADDR == a) && PSTRB[0];
  endsequence

  sequence s_setup_rd;
    setup && !PWRITE;
  endsequence

  a_apb_ready: assert property (setup |=> PREADY ##1 !PREADY)
    else $error("ready not one cycle after setup");

  a_cnt_hi_mask: assert property (
    s_setup_wr(8'h8C) ##1 PREADY |=>
      ps1_w == {4'h0, $past(PWDATA[3:0])})
    else $error("panel count high not masked");

  a_pnl_count: assert property (
    PANEL_SPREAD_COUNT == $past(pcnt_w))
    else $error("panel count not joined");

  a_ss_gain: assert property (
    PANEL_SPREAD_GAIN == (4'h1 << $past(pg_w[7:6])))
    else $error("spread gain decode wrong");

  a_det_code4: assert property (
    $past(pg_w[4:2]) == 3'h4 |-> PANEL_DETECTOR_GAIN == 8'h10)
    else $error("detector gain decode wrong");

  a_osd_div: assert property (
    PANEL_SCALER_DIV == (4'h1 << $past(pg_w[1:0])))
    else $error("scaler decode wrong");

  a_ref_sel: assert property (
    PANEL_REF_SEL == $past(po_w[2]))
    else $error("reference select wrong");

  a_spread_en: assert property (
    $rose(po_w[1]) |=> PANEL_SPREAD_EN)
    else $error("spread enable late");

  a_panel_oe: assert property (
    s_setup_wr(8'h94) ##1 PREADY && !PSLVERR |=> ##1
      PANEL_CLK_OE == $past(PWDATA[0], 2))
    else $error("panel output enable not applied");

  a_pnl_terms: assert property (
    PANEL_FB_TERM == {1'b0, $past(q[S_PN])} + 9'h008
    && PANEL_REF_TERM == {1'b0, $past(q[S_PM])} + 9'h002)
    else $error("panel terms wrong");

  a_mem_ref_wr: assert property (
    s_setup_wr(8'h98) ##1 PREADY |=> q[S_MM] == $past(PWDATA[7:0]))
    else $error("memory reference divider not stored");

  a_mem_fb_wr: assert property (
    s_setup_wr(8'h9C) ##1 PREADY |=> ##1
      MEM_FB_TERM == {1'b0, $past(PWDATA[7:0], 2)} + 9'h008)
    else $error("memory feedback divider not applied");

  a_mem_terms: assert property (
    MEM_REF_TERM == {1'b0, $past(q[S_MM])} + 9'h002)
    else $error("memory reference term wrong");

  a_mem_count: assert property (
    MEM_SPREAD_COUNT == $past(mcnt_w))
    else $error("memory count not joined");

  a_reset_zero: assert property (
    $fell(RST) |-> !PANEL_CLK_OE && !PANEL_SPREAD_EN
      && PANEL_SCALER_DIV == 4'h1 && MEM_FB_TERM == 9'h008)
    else $error("outputs not cleared by reset");

  a_rd_reserved: assert property (
    s_setup_rd ##1 PREADY |-> PRDATA[31:8] == 24'h00_0000)
    else $error("read upper bits not zero");

  // ==========================================================
  // Access refusal and readback
  // ==========================================================
  // An errored access must never reach a register
  a_err_no_write: assert property (
    PSEL && PENABLE && PREADY && PSLVERR |-> !wr.wen)
    else $error("errored write reached a register");

  a_err_misalign: assert property (
    setup && (PADDR[1:0] != 2'b00) |=> PSLVERR)
    else $error("misaligned access not refused");

  // Lane 0 strobe low leaves the memory divider alone
  a_strb_ignored: assert property (
    setup && PWRITE && (PADDR == 8'h98) && !PSTRB[0] ##1 PREADY |=> $stable(q[S_MM]))
    else $error("write without lane strobe stored");

  // Read answer carries the byte stored at setup time
  a_rd_mem_ref: assert property (
    s_setup_rd ##1 PREADY && (PADDR == 8'h98) |-> PRDATA[7:0] == $past(q[S_MM]))
    else $error("memory reference divider read wrong");

  // Status mirrors the registered output enable
  a_status_oe: assert property (
    s_setup_rd ##1 PREADY && (PADDR == 8'hBC) |-> PRDATA[0] == $past(PANEL_CLK_OE))
    else $error("status output enable bit wrong");

  // ==========================================================
  // Outputs follow their fields one edge later; reserved stored bits stay clear
  // ==========================================================
  a_det_gain_all: assert property (
    PANEL_DETECTOR_GAIN == (8'h01 << $past(pg_w[4:2])))
    else $error("detector gain not a power of two");

  a_oe_follow: assert property (
    PANEL_CLK_OE == $past(po_w[0]))
    else $error("panel output enable not following");

  a_en_follow: assert property (
    PANEL_SPREAD_EN == $past(po_w[1]))
    else $error("spread enable not following");

  a_mem_fb_term: assert property (
    MEM_FB_TERM == {1'b0, $past(q[S_MN])} + 9'h008)
    else $error("memory feedback term wrong");

  // Masking keeps reserved positions clear whatever was written
  a_rsvd_clear: assert property (
    ps1_w[7:4] == 4'h0 && pg_w[5] == 1'b0 && po_w[7:3] == 5'h00)
    else $error("reserved bits stored");

endmodule // acp_config_top
`default_nettype wire

// ==== design/acp_pkg.sv ====
// Package: constants for the auxiliary synthesizer configuration block
package acp_pkg;

  // ==========================================================
  // Register slots and indices (byte address = 4 * index)
  // ==========================================================
  localparam int ACP_NREG = 10;
  localparam int S_PM = 0;   // Panel reference divider
  localparam int S_PN = 1;   // Panel feedback divider
  localparam int S_PS0 = 2;  // Panel spread count low
  localparam int S_PS1 = 3;  // Panel spread count high
  localparam int S_PG = 4;   // Panel gain and scaler
  localparam int S_PO = 5;   // Panel output control
  localparam int S_MM = 6;   // Memory reference divider
  localparam int S_MN = 7;   // Memory feedback divider
  localparam int S_MS0 = 8;  // Memory spread count low
  localparam int S_MS1 = 9;  // Memory spread count high
  localparam logic [ACP_NREG-1:0][7:0] ACP_IDX = {
    8'h29, 8'h28, 8'h27, 8'h26, 8'h25,
    8'h24, 8'h23, 8'h22, 8'h21, 8'h20};
  // Writable bits per slot; reserved bits never store
  localparam logic [ACP_NREG-1:0][7:0] ACP_MASK = {
    8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h07,
    8'hDF, 8'h0F, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] ACP_IDX_STATUS = 8'h2F;
  localparam logic [7:0] ACP_RST_VAL = 8'h00;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int F_SSG_HI = 7;
  localparam int F_SSG_LO = 6;
  localparam int F_DET_HI = 4;
  localparam int F_DET_LO = 2;
  localparam int F_OSD_HI = 1;
  localparam int F_OSD_LO = 0;
  localparam int F_REF_SEL = 2;
  localparam int F_SS_EN = 1;
  localparam int F_OE = 0;
  localparam int F_CNT_HI_W = 4;

  // ==========================================================
  // Synthesizer equation offsets: f = ref * (N + 8) / (M + 2)
  // ==========================================================
  localparam logic [8:0] ACP_N_ADD = 9'h008;
  localparam logic [8:0] ACP_M_ADD = 9'h002;

endpackage : acp_pkg

// ==== design/acp_pll_decode.sv ====
// Module: synthesizer divider terms and spread count assembly
`timescale 1ns/10ps
`default_nettype none
module acp_pll_decode
  import acp_pkg::*;
(
  input wire logic clk,            // System clock
  input wire logic rst,            // Sync reset, high
  input wire logic [7:0] ref_div,  // M field
  input wire logic [7:0] fb_div,   // N field
  input wire logic [7:0] cnt_lo,   // Spread count bits 7:0
  input wire logic [7:0] cnt_hi,   // Spread count bits 11:8 in low nibble
  output logic [8:0] fb_term,      // N + 8
  output logic [8:0] ref_term,     // M + 2
  output logic [11:0] spread_cnt   // Twelve-bit spread count
);

  // ==========================================================
  // Registered terms
  // ==========================================================
  // Nine bits hold 255 + 8 without wrap
  // Reset shows the terms of zero fields, so no bogus zero divider leaks out
  always_ff @(posedge clk) begin
    if (rst) begin
      fb_term <= ACP_N_ADD;
      ref_term <= ACP_M_ADD;
    end else begin
      fb_term <= {1'b0, fb_div} + ACP_N_ADD;
      ref_term <= {1'b0, ref_div} + ACP_M_ADD;
    end
  end

  // Upper nibble joins the low byte
  always_ff @(posedge clk) begin
    if (rst) begin
      spread_cnt <= 12'h000;
    end else begin
      spread_cnt <= {cnt_hi[F_CNT_HI_W-1:0], cnt_lo};
    end
  end

endmodule // acp_pll_decode
`default_nettype wire

// ==== design/acp_wr_if.sv ====
// Interface: internal register write strobe bundle
`timescale 1ns/10ps
`default_nettype none
interface acp_wr_if;
  logic wen;
  logic [7:0] idx;
  logic [7:0] wdata;
  modport master (output wen, output idx, output wdata);
  modport slave (input wen, input idx, input wdata);
endinterface : acp_wr_if
`default_nettype wire

// ==== verif/tb_acp_config_top.sv ====
// Self-checking testbench for the synthesizer configuration register block
`timescale 1ns/10ps
`default_nettype none
module tb_acp_config_top;
  import acp_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  logic SYS_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [3:0] PSTRB;
  logic PANEL_CLK_OE, PANEL_SPREAD_EN, PANEL_REF_SEL;
  logic [3:0] PANEL_SPREAD_GAIN, PANEL_SCALER_DIV;
  logic [7:0] PANEL_DETECTOR_GAIN;
  logic [11:0] PANEL_SPREAD_COUNT, MEM_SPREAD_COUNT;
  logic [8:0] PANEL_FB_TERM, PANEL_REF_TERM, MEM_FB_TERM, MEM_REF_TERM;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic er;

  // Device under test, no input tied off
  acp_config_top acp_config_top_i (
    .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .PANEL_CLK_OE(PANEL_CLK_OE), .PANEL_SPREAD_EN(PANEL_SPREAD_EN),
    .PANEL_REF_SEL(PANEL_REF_SEL), .PANEL_SPREAD_GAIN(PANEL_SPREAD_GAIN),
    .PANEL_DETECTOR_GAIN(PANEL_DETECTOR_GAIN), .PANEL_SCALER_DIV(PANEL_SCALER_DIV),
    .PANEL_SPREAD_COUNT(PANEL_SPREAD_COUNT), .PANEL_FB_TERM(PANEL_FB_TERM),
    .PANEL_REF_TERM(PANEL_REF_TERM), .MEM_SPREAD_COUNT(MEM_SPREAD_COUNT),
    .MEM_FB_TERM(MEM_FB_TERM), .MEM_REF_TERM(MEM_REF_TERM));

  // 200 MHz clock
  initial SYS_CLK = 1'b0;
  always #2.5 SYS_CLK = ~SYS_CLK;

  // ==========================================================
  // Shared tasks
  // ==========================================================
  // Value compare, four-state so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for ready, never a fixed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [3:0] st);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    PSTRB <= st;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    // A missing ready is left to the watchdog
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Byte address is four times the register index
  function automatic logic [7:0] ad(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

  task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, ad(idx), {24'h00_0000, v}, 4'h1);
  endtask

  // Read a register, expect the word and no error
  task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, ad(idx), 32'h0000_0000, 4'h0);
    chk(rd, {24'h00_0000, exp});
    chk(er, 1'b0);
  endtask

  // Derived outputs land one edge after the write edge
  task automatic settle();
    @(posedge SYS_CLK);
    #1;
  endtask

  // Every output at its cleared meaning
  task automatic chk_idle();
    chk({PANEL_CLK_OE, PANEL_SPREAD_EN, PANEL_REF_SEL}, 3'b000);
    chk({PANEL_SPREAD_GAIN, PANEL_SCALER_DIV, PANEL_DETECTOR_GAIN}, 16'h1101);
    chk({PANEL_SPREAD_COUNT, MEM_SPREAD_COUNT}, 24'h00_0000);
    chk({PANEL_FB_TERM, PANEL_REF_TERM}, {9'h008, 9'h002});
    chk({MEM_FB_TERM, MEM_REF_TERM}, {9'h008, 9'h002});
    for (int i = 0; i < ACP_NREG; i++) begin
      rreg(ACP_IDX[i], 8'h00);
    end
    rreg(ACP_IDX_STATUS, 8'h00);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  // Distinct patterns everywhere first, then read back to catch aliasing
  task automatic t_readback();
    for (int i = 0; i < ACP_NREG; i++) begin
      wreg(ACP_IDX[i], (8'hC3 ^ 8'(i)) & ACP_MASK[i]);
    end
    for (int i = 0; i < ACP_NREG; i++) begin
      rreg(ACP_IDX[i], (8'hC3 ^ 8'(i)) & ACP_MASK[i]);
    end
  endtask

  // Every gain and scaler code
  task automatic t_gain();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wreg(8'h24, {c[1:0], 1'b0, c, c[1:0]});
      settle();
      chk(PANEL_SPREAD_GAIN, 4'h1 << c[1:0]);
      chk(PANEL_DETECTOR_GAIN, 8'h01 << c);
      chk(PANEL_SCALER_DIV, 4'h1 << c[1:0]);
    end
  endtask

  // All combinations of the three control bits
  task automatic t_ctrl();
    logic [2:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      wreg(8'h25, {5'b00000, v});
      settle();
      chk(PANEL_CLK_OE, v[0]);
      chk(PANEL_SPREAD_EN, v[1]);
      chk(PANEL_REF_SEL, v[2]);
      // Panel count is nonzero here, so status bit 1 tracks the enable
      rreg(ACP_IDX_STATUS, {4'h0, v[0] & v[1], v[2], v[1], v[0]});
    end
  endtask

  // Divider terms and counts, full-scale and a mixed pattern
  task automatic t_terms();
    logic [7:0] v;
    for (int j = 0; j < 2; j++) begin
      v = (j == 0) ? 8'hFF : 8'h3C;
      wreg(8'h20, v);
      wreg(8'h21, ~v);
      wreg(8'h22, v);
      wreg(8'h23, ~v & 8'h0F);
      wreg(8'h26, ~v);
      wreg(8'h27, v);
      wreg(8'h28, ~v);
      wreg(8'h29, v & 8'h0F);
      settle();
      chk(PANEL_REF_TERM, {1'b0, v} + 9'h002);
      chk(PANEL_FB_TERM, {1'b0, ~v} + 9'h008);
      chk(PANEL_SPREAD_COUNT, {~v[3:0], v});
      chk(MEM_REF_TERM, {1'b0, ~v} + 9'h002);
      chk(MEM_FB_TERM, {1'b0, v} + 9'h008);
      chk(MEM_SPREAD_COUNT, {v[3:0], ~v});
    end
  endtask

  // Refused accesses leave state alone
  task automatic t_err();
    apb(1'b0, 8'hB0, 32'h0000_0000, 4'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 8'h81, 32'h0000_0011, 4'h1);
    chk(er, 1'b1);
    apb(1'b1, ad(8'h26), 32'h0000_0011, 4'h0);
    chk(er, 1'b0);
    rreg(8'h20, 8'h3C);
    rreg(8'h26, 8'hC3);
  endtask

  // Reset in mid-run clears everything again
  task automatic t_rst();
    @(posedge SYS_CLK);
    RST <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    RST <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk_idle();
  endtask

  // ==========================================================
  // Verdict and main sequence
  // ==========================================================
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run is well under 2000 cycles
  initial begin
    #20000;
    n_errors++;
    final_report();
  end

  // Reset for ten cycles, then the scenarios
  initial begin
    RST = 1'b1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = '0;
    repeat (10) @(posedge SYS_CLK);
    RST <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk_idle();
    t_readback();
    t_gain();
    t_ctrl();
    t_terms();
    t_err();
    t_rst();
    final_report();
  end
endmodule // tb_acp_config_top
`default_nettype wire
